// ==== dmr_buffer.sv ====
`timescale 1ns/10ps
module dmr_buffer #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 2
) (
  input  wire logic             i_clock,
  input  wire logic             i_reset_n,
  input  wire logic             i_clk_en,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic [WIDTH-1:0]      o_out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      used_q;
  wire              push = i_in_valid && o_in_ready;
  wire              pop  = o_out_valid && i_out_ready;

  assign o_in_ready  = (used_q != (AW+1)'(DEPTH));
  assign o_out_valid = (used_q != '0);
  assign o_out_data  = mem_q[rd_q];

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
  endfunction

  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      wr_q   <= '0;
      rd_q   <= '0;
      used_q <= '0;
    end else if (i_clk_en) begin
      if (push) begin
        mem_q[wr_q] <= i_in_data;
        wr_q        <= bump(wr_q);
      end
      if (pop) begin
        rd_q <= bump(rd_q);
      end
      if (push && !pop) begin
        used_q <= used_q + 1'b1;
      end else if (pop && !push) begin
        used_q <= used_q - 1'b1;
      end
    end
  end
endmodule

// ==== dmr_channel.sv ====
`timescale 1ns/10ps
module dmr_channel #(
  parameter int unsigned CHANNEL_INDEX = 2,
  parameter int          BUF_DEPTH     = 2
) (
  input  wire logic              i_clock,
  input  wire logic              i_reset_n,
  input  wire logic              i_clk_en,
  input  wire dmr_pkg::dmr_cfg_t i_cfg,
  input  wire logic [31:0]       i_src_start,
  input  wire logic [31:0]       i_dst_start,
  input  wire logic [31:0]       i_count_start,
  input  wire logic              i_load,
  input  wire logic              i_chan_en,
  input  wire logic              i_master_en,
  input  wire logic              i_dreq,
  input  wire logic              i_nmi,
  input  wire logic              i_addr_err,
  input  wire logic              i_standby,
  input  wire logic              i_oper_wr,
  input  wire logic              i_oper_wr_16,
  input  wire logic              i_oper_flag_clr,
  input  wire logic              i_te_clr,
  input  wire logic              i_mem_ack,
  input  wire logic [31:0]       i_mem_rdata,
  output dmr_pkg::dmr_mem_t      o_mem,
  output logic                   o_bus_req,
  output logic [31:0]            o_src_addr,
  output logic [31:0]            o_dst_addr,
  output logic [31:0]            o_count,
  output logic                   o_te,
  output logic                   o_irq,
  output logic                   o_req_clear,
  output logic                   o_nmi_flag,
  output logic                   o_ae_flag,
  output logic                   o_oper_size_err
);

  ////////////////////////////////////////////////////////////////////////////
  // state and storage
  typedef enum logic [1:0] {S_IDLE, S_PTR, S_RD, S_WR} dmr_state_t;

  dmr_state_t        state_q;
  dmr_pkg::dmr_cfg_t cfg_q;
  dmr_pkg::dmr_mem_t mem_q;
  logic [31:0]       src_q, dst_q, count_q, start_q;
  logic [1:0]        reload_q;
  logic              cont_q, bus_q, te_q, irq_q, clr_q;
  logic              nmi_q, ae_q, size_err_q;
  logic              nmi_s1_q, nmi_s2_q, nmi_s3_q;

  ////////////////////////////////////////////////////////////////////////////
  // decode
  function automatic logic [31:0] step(input logic [31:0] a, input logic [1:0] mode,
                                       input logic [1:0] size);
    logic [31:0] inc;
    inc = (size == dmr_pkg::SZ_LONG) ? 32'h0000_0004 :
          (size == dmr_pkg::SZ_WORD) ? 32'h0000_0002 : 32'h0000_0001;
    step = (mode == dmr_pkg::STEP_INC) ? a + inc :
           (mode == dmr_pkg::STEP_DEC) ? a - inc : a;
  endfunction

  wire reload_en  = (CHANNEL_INDEX == dmr_pkg::RELOAD_CHANNEL) && cfg_q.reload_on;
  wire nmi_rise   = nmi_s2_q && !nmi_s3_q;
  wire oper_ok    = i_oper_wr && i_oper_wr_16;
  wire abort      = !i_master_en || !i_chan_en || nmi_q || ae_q;
  wire start_ok   = !abort && !i_standby && (count_q != '0) && (i_dreq || cont_q);
  wire rd_ack     = (state_q == S_RD) && mem_q.valid && i_mem_ack;
  wire ptr_ack    = (state_q == S_PTR) && mem_q.valid && i_mem_ack;
  wire wr_ack     = (state_q == S_WR) && mem_q.valid && i_mem_ack;
  wire [31:0] cnt_next = count_q - 32'h0000_0001;
  wire grp_end    = reload_en && (reload_q == dmr_pkg::RELOAD_LAST);
  wire last_unit  = (cnt_next == '0);
  wire go_on      = cfg_q.burst && !grp_end && !last_unit && !abort;
  wire reload_rst = !i_master_en || !i_chan_en || nmi_rise || i_addr_err ||
                    i_standby || (wr_ack && last_unit);
  wire [1:0] data_size = cfg_q.size;

  logic        buf_in_ready, buf_out_valid;
  logic [31:0] buf_out_data;

  // the read data waits here so a slow write side never drops a word
  dmr_buffer #(.WIDTH(32), .DEPTH(BUF_DEPTH)) u_buffer (
    .i_clock     (i_clock),
    .i_reset_n   (i_reset_n),
    .i_clk_en    (i_clk_en),
    .i_in_valid  (rd_ack),
    .o_in_ready  (buf_in_ready),
    .i_in_data   (i_mem_rdata),
    .o_out_valid (buf_out_valid),
    .i_out_ready (wr_ack),
    .o_out_data  (buf_out_data)
  );

  assign o_mem           = mem_q;
  assign o_bus_req       = bus_q;
  assign o_src_addr      = src_q;
  assign o_dst_addr      = dst_q;
  assign o_count         = count_q;
  assign o_te            = te_q;
  assign o_irq           = irq_q;
  assign o_req_clear     = clr_q;
  assign o_nmi_flag      = nmi_q;
  assign o_ae_flag       = ae_q;
  assign o_oper_size_err = size_err_q;

  ////////////////////////////////////////////////////////////////////////////
  // nmi pin synchroniser and operation register flags
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      nmi_s1_q <= 1'b0;
      nmi_s2_q <= 1'b0;
      nmi_s3_q <= 1'b0;
    end else if (i_clk_en) begin
      nmi_s1_q <= i_nmi;
      nmi_s2_q <= nmi_s1_q;
      nmi_s3_q <= nmi_s2_q;
    end
  end

  // a flag raised in the clearing cycle survives the clear
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      nmi_q      <= 1'b0;
      ae_q       <= 1'b0;
      size_err_q <= 1'b0;
    end else if (i_clk_en) begin
      nmi_q      <= nmi_rise || (nmi_q && !(oper_ok && i_oper_flag_clr));
      ae_q       <= i_addr_err || (ae_q && !(oper_ok && i_oper_flag_clr));
      size_err_q <= i_oper_wr && !i_oper_wr_16;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // channel registers
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      cfg_q   <= '0;
      src_q   <= dmr_pkg::ADDR_RESET;
      start_q <= dmr_pkg::ADDR_RESET;
      dst_q   <= dmr_pkg::ADDR_RESET;
      count_q <= dmr_pkg::COUNT_RESET;
    end else if (i_clk_en) begin
      if (i_load) begin
        cfg_q   <= i_cfg;
        src_q   <= i_src_start;
        start_q <= i_src_start;
        dst_q   <= i_dst_start;
        count_q <= i_count_start;
      end else begin
        if (ptr_ack) begin
          src_q <= step(src_q, cfg_q.src_mode, dmr_pkg::SZ_LONG);
        end else if (rd_ack && !cfg_q.indirect) begin
          src_q <= step(src_q, cfg_q.src_mode, data_size);
        end else if (wr_ack && grp_end) begin
          src_q <= start_q;
        end
        if (wr_ack) begin
          dst_q   <= step(dst_q, cfg_q.dst_mode, data_size);
          count_q <= cnt_next;
        end
      end
    end
  end

  // four-transfer group counter; address registers are left alone on stop
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      reload_q <= dmr_pkg::RELOAD_RESET;
    end else if (i_clk_en) begin
      if (reload_rst || i_load) begin
        reload_q <= dmr_pkg::RELOAD_RESET;
      end else if (wr_ack && reload_en) begin
        reload_q <= reload_q + 2'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transfer sequencer
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      state_q <= S_IDLE;
      mem_q   <= '0;
      cont_q  <= 1'b0;
      bus_q   <= 1'b0;
    end else if (i_clk_en) begin
      case (state_q)
        S_IDLE: begin
          if (start_ok && buf_in_ready) begin
            bus_q       <= 1'b1;
            mem_q.valid <= 1'b1;
            mem_q.write <= 1'b0;
            mem_q.addr  <= src_q;
            if (cfg_q.indirect) begin
              mem_q.size <= dmr_pkg::SZ_LONG;
              state_q    <= S_PTR;
            end else begin
              mem_q.size <= data_size;
              state_q    <= S_RD;
            end
          end else begin
            cont_q <= cont_q && !abort;
            bus_q  <= cont_q && !abort;
          end
        end
        S_PTR: begin
          if (ptr_ack) begin
            mem_q.addr <= i_mem_rdata;
            mem_q.size <= data_size;
            state_q    <= S_RD;
          end
        end
        S_RD: begin
          if (rd_ack) begin
            mem_q.valid <= 1'b0;
            state_q     <= S_WR;
          end
        end
        default: begin
          if (!mem_q.valid && buf_out_valid && !wr_ack) begin
            mem_q.valid <= 1'b1;
            mem_q.write <= 1'b1;
            mem_q.size  <= data_size;
            mem_q.addr  <= dst_q;
            mem_q.wdata <= buf_out_data;
          end else if (wr_ack) begin
            mem_q.valid <= 1'b0;
            mem_q.write <= 1'b0;
            cont_q      <= go_on;
            bus_q       <= go_on;
            state_q     <= S_IDLE;
          end
        end
      endcase
    end
  end

  // end-of-transfer flag, interrupt and request-source clear
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      te_q  <= 1'b0;
      irq_q <= 1'b0;
      clr_q <= 1'b0;
    end else if (i_clk_en) begin
      te_q  <= (wr_ack && last_unit) || (te_q && !i_te_clr && !i_load);
      irq_q <= wr_ack && last_unit && cfg_q.int_en;
      clr_q <= wr_ack && (last_unit || grp_end);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  reload_halt_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (i_clk_en && wr_ack && grp_end && !i_load) |=> (src_q == $past(start_q)) && !bus_q && clr_q)
    else $error("reload group end did not restore source and release bus");

  burst_keep_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (i_clk_en && wr_ack && !reload_en && cfg_q.burst && !last_unit && !abort) |=> bus_q)
    else $error("burst without reload dropped the bus");

  irq_cause_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    irq_q |-> (count_q == '0) && te_q && cfg_q.int_en)
    else $error("end interrupt without count at zero");

  dst_step_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (i_clk_en && wr_ack && !i_load && cfg_q.dst_mode == dmr_pkg::STEP_INC)
      |=> dst_q != $past(dst_q))
    else $error("destination did not step");

  ptr_long_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (state_q == S_PTR && mem_q.valid) |-> mem_q.size == dmr_pkg::SZ_LONG)
    else $error("pointer read not longword");

  ptr_then_data_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (i_clk_en && ptr_ack) |=> state_q == S_RD && mem_q.addr == $past(i_mem_rdata))
    else $error("data read not taken from fetched pointer");

  nmi_set_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (i_clk_en && nmi_rise) |=> nmi_q)
    else $error("nmi flag not set");

  oper_size_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (i_clk_en && i_oper_wr && !i_oper_wr_16 && !nmi_rise && !i_addr_err)
      |=> size_err_q && nmi_q == $past(nmi_q) && ae_q == $past(ae_q))
    else $error("non-16-bit operation write took effect");

  reload_clear_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (i_clk_en && (!i_chan_en || !i_master_en || i_standby))
      |=> reload_q == dmr_pkg::RELOAD_RESET)
    else $error("reload counter not cleared");

endmodule

// ==== dmr_channel_test.sv ====
`timescale 1ns/10ps
module dmr_channel_test;
  typedef struct {
    logic               ld;
    logic               ab;
    dmr_pkg::dmr_cfg_t  cfg;
    logic [31:0]        src;
    logic [31:0]        dst;
    logic [31:0]        cnt;
    logic [3:0]         dly;
    logic [31:0]        e_src;
    logic [31:0]        e_dst;
    logic [31:0]        e_cnt;
    logic               e_te;
    int                 e_irq;
    int                 e_clr;
  } dmr_row_t;

  localparam logic [31:0] S0 = 32'h0000_1000;
  localparam logic [31:0] D0 = 32'h0000_2000;

  logic              i_clock;
  logic              i_reset_n;
  dmr_pkg::dmr_cfg_t cfg;
  logic [31:0]       src_s, dst_s, cnt_s, rdata, src_a, dst_a, cnt_a;
  logic              load, chan_en, master_en, dreq, nmi, aerr, standby, clk_en;
  logic              owr, owr16, oclr, te_clr, ack, bus_req, te, irq, req_clr;
  logic              nmi_f, ae_f, size_err;
  logic [3:0]        delay;
  dmr_pkg::dmr_mem_t mem;
  int                miscompares, check_count, irq_n, clr_n;
  dmr_row_t          rows [7];

  dmr_channel #(.CHANNEL_INDEX(2), .BUF_DEPTH(2)) dut (
    .i_clock(i_clock), .i_reset_n(i_reset_n), .i_clk_en(clk_en), .i_cfg(cfg),
    .i_src_start(src_s), .i_dst_start(dst_s), .i_count_start(cnt_s), .i_load(load),
    .i_chan_en(chan_en), .i_master_en(master_en), .i_dreq(dreq), .i_nmi(nmi),
    .i_addr_err(aerr), .i_standby(standby), .i_oper_wr(owr), .i_oper_wr_16(owr16),
    .i_oper_flag_clr(oclr), .i_te_clr(te_clr), .i_mem_ack(ack), .i_mem_rdata(rdata),
    .o_mem(mem), .o_bus_req(bus_req), .o_src_addr(src_a), .o_dst_addr(dst_a),
    .o_count(cnt_a), .o_te(te), .o_irq(irq), .o_req_clear(req_clr), .o_nmi_flag(nmi_f),
    .o_ae_flag(ae_f), .o_oper_size_err(size_err));

  dmr_mem_model far_mem (
    .i_clock(i_clock), .i_reset_n(i_reset_n), .i_delay(delay), .i_mem(mem),
    .o_ack(ack), .o_rdata(rdata));

  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end

  always @(posedge i_clock) begin
    if (irq === 1'b1) irq_n++;
    if (req_clr === 1'b1) clr_n++;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task print_verdict;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // burst is always chosen, reload needs it
  function automatic dmr_pkg::dmr_cfg_t mk(input logic [1:0] sm, dm, sz, input logic [2:0] f);
    mk = '{sm, dm, sz, 1'b1, f[2], f[1], f[0]};
  endfunction

  task automatic run_row(input dmr_row_t r);
    int n;
    irq_n = 0;
    clr_n = 0;
    far_mem.rd_log.delete();
    delay <= r.dly;
    @(posedge i_clock);
    if (r.ld) begin
      cfg   <= r.cfg;
      src_s <= r.src;
      dst_s <= r.dst;
      cnt_s <= r.cnt;
      load  <= 1'b1;
      @(posedge i_clock);
      load  <= 1'b0;
    end
    dreq <= 1'b1;
    @(posedge i_clock);
    dreq <= 1'b0;
    if (r.ab) begin
      repeat (2) @(posedge i_clock);
      master_en <= 1'b0;
    end
    n = 0;
    while (bus_req !== 1'b1 && n < 20) begin
      @(posedge i_clock);
      n++;
    end
    // a channel that never takes the bus counts as hung
    if (bus_req !== 1'b1) n = 2000;
    while (bus_req !== 1'b0 && n < 2000) begin
      @(posedge i_clock);
      n++;
    end
    repeat (4) @(posedge i_clock);
    master_en <= 1'b1;
    chk(32'(n < 2000), 32'h0000_0001, "transfer hung");
    chk(src_a, r.e_src, "source address");
    chk(dst_a, r.e_dst, "destination address");
    chk(cnt_a, r.e_cnt, "count");
    chk(32'(te), 32'(r.e_te), "end flag");
    chk(irq_n, r.e_irq, "end interrupts");
    chk(clr_n, r.e_clr, "request clears");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    i_reset_n = 1'b0;
    {load, dreq, nmi, aerr, standby, owr, owr16, oclr, te_clr} = 9'h000;
    {chan_en, master_en, clk_en} = 3'h7;
    cfg   = '0;
    src_s = '0;
    dst_s = '0;
    cnt_s = '0;
    delay = 4'h0;
    miscompares = 0;
    check_count = 0;
    far_mem.store[S0] = 32'h0000_4000;
    far_mem.store[32'h0000_1004] = 32'h0000_5000;
    far_mem.store[32'h0000_5000] = 32'h0000_00a5;
    rows[0] = '{1'b1, 1'b0, mk(dmr_pkg::STEP_INC, dmr_pkg::STEP_INC, dmr_pkg::SZ_BYTE, 3'h5),
      S0, D0, 32'h0000_0008, 4'h0, S0, 32'h0000_2004, 32'h0000_0004, 1'b0, 0, 1};
    rows[1] = '{1'b0, 1'b0, rows[0].cfg,
      S0, D0, 32'h0000_0008, 4'h2, S0, 32'h0000_2008, 32'h0000_0000, 1'b1, 1, 1};
    rows[2] = '{1'b1, 1'b0, mk(dmr_pkg::STEP_INC, dmr_pkg::STEP_INC, dmr_pkg::SZ_BYTE, 3'h1),
      S0, D0, 32'h0000_0008, 4'h1, 32'h0000_1008, 32'h0000_2008, 32'h0000_0000, 1'b1, 1, 1};
    rows[3] = '{1'b1, 1'b0, mk(dmr_pkg::STEP_DEC, dmr_pkg::STEP_FIXED, dmr_pkg::SZ_WORD, 3'h0),
      S0, D0, 32'h0000_0003, 4'h0, 32'h0000_0ffa, D0, 32'h0000_0000, 1'b1, 0, 1};
    rows[4] = '{1'b1, 1'b0, mk(dmr_pkg::STEP_FIXED, dmr_pkg::STEP_DEC, dmr_pkg::SZ_LONG, 3'h1),
      S0, D0, 32'h0000_0002, 4'h3, S0, 32'h0000_1ff8, 32'h0000_0000, 1'b1, 1, 1};
    rows[5] = '{1'b1, 1'b1, mk(dmr_pkg::STEP_INC, dmr_pkg::STEP_INC, dmr_pkg::SZ_BYTE, 3'h4),
      S0, D0, 32'h0000_0008, 4'h3, 32'h0000_1001, 32'h0000_2001, 32'h0000_0007, 1'b0, 0, 0};
    rows[6] = '{1'b1, 1'b0, mk(dmr_pkg::STEP_INC, dmr_pkg::STEP_FIXED, dmr_pkg::SZ_BYTE, 3'h2),
      S0, 32'h0000_3000, 32'h0000_0002, 4'h1, 32'h0000_1008, 32'h0000_3000, 32'h0000_0000,
      1'b1, 0, 1};
    repeat (3) @(posedge i_clock);
    i_reset_n <= 1'b1;
    @(posedge i_clock);
    #1;
    chk(32'({bus_req, te, nmi_f, ae_f, mem.valid}), 32'h0000_0000, "flags after reset");
    chk(cnt_a, 32'h0000_0000, "count after reset");
    foreach (rows[i]) run_row(rows[i]);
    chk(far_mem.rd_log[0], {dmr_pkg::SZ_LONG, 30'h0000_1000}, "pointer read");
    chk(far_mem.rd_log[1], {dmr_pkg::SZ_BYTE, 30'h0000_4000}, "data read");
    chk(far_mem.rd_log[2], {dmr_pkg::SZ_LONG, 30'h0000_1004}, "second pointer");
    chk(far_mem.last_waddr, 32'h0000_3000, "write address");
    chk(32'(far_mem.last_wdata[7:0]), 32'h0000_00a5, "write data");
    @(posedge i_clock);
    te_clr <= 1'b1;
    nmi    <= 1'b1;
    aerr   <= 1'b1;
    @(posedge i_clock);
    {te_clr, nmi, aerr} <= 3'h0;
    repeat (4) @(posedge i_clock);
    #1;
    chk(32'(te), 32'h0000_0000, "end flag clear");
    chk(32'(nmi_f), 32'h0000_0001, "nmi flag while idle");
    chk(32'(ae_f), 32'h0000_0001, "address error flag");
    @(posedge i_clock);
    owr  <= 1'b1;
    oclr <= 1'b1;
    @(posedge i_clock);
    owr <= 1'b0;
    #1;
    chk(32'(size_err), 32'h0000_0001, "long operation write refused");
    @(posedge i_clock);
    #1;
    chk(32'({nmi_f, ae_f}), 32'h0000_0003, "flags kept by refused write");
    @(posedge i_clock);
    owr   <= 1'b1;
    owr16 <= 1'b1;
    @(posedge i_clock);
    owr  <= 1'b0;
    oclr <= 1'b0;
    @(posedge i_clock);
    #1;
    chk(32'({nmi_f, ae_f, size_err}), 32'h0000_0000, "word write clears flags");
    // reset in mid-run must return the programmed addresses to their reset values
    @(posedge i_clock);
    i_reset_n <= 1'b0;
    repeat (3) @(posedge i_clock);
    i_reset_n <= 1'b1;
    @(posedge i_clock);
    #1;
    chk(src_a, dmr_pkg::ADDR_RESET, "source after mid-run reset");
    chk(dst_a, dmr_pkg::ADDR_RESET, "destination after mid-run reset");
    print_verdict();
  end

  // every scenario together needs well under 20000 cycles
  initial begin
    #200000;
    miscompares++;
    $display("[FAIL] %0t watchdog expired", $time);
    print_verdict();
  end
endmodule

// ==== dmr_mem_model.sv ====
`timescale 1ns/10ps
module dmr_mem_model (
  input  wire logic              i_clock,
  input  wire logic              i_reset_n,
  input  wire logic [3:0]        i_delay,
  input  wire dmr_pkg::dmr_mem_t i_mem,
  output logic                   o_ack,
  output logic [31:0]            o_rdata
);
  logic [31:0] store [logic [31:0]];
  logic [31:0] rd_log [$];
  logic [31:0] last_waddr;
  logic [31:0] last_wdata;
  logic [3:0]  wait_q;

  ////////////////////////////////////////////////////////////////////////////
  // one access at a time, answered after i_delay idle cycles
  always @(posedge i_clock) begin
    if (!i_reset_n) begin
      o_ack   <= 1'b0;
      wait_q  <= 4'h0;
      o_rdata <= 32'h5a5a_a5a5;
    end else begin
      o_ack   <= 1'b0;
      // outside an answer the data lines toggle, so a stale read never matches
      o_rdata <= ~o_rdata;
      if (i_mem.valid && !o_ack) begin
        if (wait_q >= i_delay) begin
          o_ack  <= 1'b1;
          wait_q <= 4'h0;
          if (i_mem.write) begin
            last_waddr <= i_mem.addr;
            last_wdata <= i_mem.wdata;
          end else begin
            o_rdata <= store.exists(i_mem.addr) ? store[i_mem.addr] : ~i_mem.addr;
            rd_log.push_back({i_mem.size, i_mem.addr[29:0]});
          end
        end else begin
          wait_q <= wait_q + 4'h1;
        end
      end
    end
  end
endmodule

// ==== dmr_pkg.sv ====
package dmr_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // transfer unit sizes and address step modes
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_WORD = 2'h1;
  localparam logic [1:0] SZ_LONG = 2'h2;

  localparam logic [1:0] STEP_FIXED = 2'h0;
  localparam logic [1:0] STEP_INC   = 2'h1;
  localparam logic [1:0] STEP_DEC   = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // reload function
  localparam int unsigned RELOAD_CHANNEL = 2;
  localparam logic [1:0]  RELOAD_LAST    = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [31:0] ADDR_RESET  = 32'h0000_0000;
  localparam logic [31:0] COUNT_RESET = 32'h0000_0000;
  localparam logic [1:0]  RELOAD_RESET = 2'h0;

  ////////////////////////////////////////////////////////////////////////////
  // channel control image, taken when the control register is written
  typedef struct packed {
    logic [1:0] src_mode;
    logic [1:0] dst_mode;
    logic [1:0] size;
    logic       burst;
    logic       reload_on;
    logic       indirect;
    logic       int_en;
  } dmr_cfg_t;

  // memory-side access request
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [1:0]  size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } dmr_mem_t;

endpackage
